// *** src/tca_align_buf.v ***
// Phase-align buffer: small pointer buffer between write and read ticks.
// Assumes write and read ticks are single-cycle strobes on clk_i.
`timescale 1ns/100ps
`include "tca_consts.vh"
module tca_align_buf (
  input wire clk_i,
  input wire resetn_i,
  input wire init_i,
  input wire wr_i,
  input wire [`TCA_CHAR_W-1:0] wdata_i,
  input wire rd_i,
  output reg [`TCA_CHAR_W-1:0] rdata_o,
  output reg err_o,
  output wire [`TCA_BUF_PW-1:0] level_o
);
  reg [`TCA_BUF_PW-1:0] wp_q;
  reg [`TCA_BUF_PW-1:0] rp_q;
  reg [`TCA_CHAR_W-1:0] mem_q [0:`TCA_BUF_DEPTH-1];
  wire full_w;
  wire empty_w;
  wire over_w;
  wire under_w;
  genvar gi;

  assign level_o = wp_q - rp_q;
  assign full_w = (level_o == `TCA_BUF_DEPTH);
  assign empty_w = (level_o == {`TCA_BUF_PW{1'b0}});
  assign over_w = wr_i & ~rd_i & full_w;
  assign under_w = rd_i & ~wr_i & empty_w;

  generate
    for (gi = 0; gi < `TCA_BUF_DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          mem_q[gi] <= {`TCA_CHAR_W{1'b0}};
        end else if (wr_i && (!full_w || rd_i) && (wp_q[1:0] == gi)) begin
          mem_q[gi] <= wdata_i;
        end
      end
    end
  endgenerate

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_q <= `TCA_BUF_CENTRE;
      rp_q <= {`TCA_BUF_PW{1'b0}};
      err_o <= 1'b0;
      rdata_o <= {`TCA_CHAR_W{1'b0}};
    end else if (init_i) begin
      // Re-centre: half-full gives wander room both ways
      wp_q <= `TCA_BUF_CENTRE;
      rp_q <= {`TCA_BUF_PW{1'b0}};
      err_o <= 1'b0;
    end else begin
      // A read in the same tick frees the slot, so a full write still lands
      if (wr_i && (!full_w || rd_i)) begin
        wp_q <= wp_q + 3'h1;
      end
      if (rd_i && !empty_w) begin
        rp_q <= rp_q + 3'h1;
        rdata_o <= mem_q[rp_q[1:0]];
      end
      if (over_w || under_w) begin
        err_o <= 1'b1;
      end
    end
  end
endmodule // tca_align_buf

// *** src/tca_consts.vh ***
// Constants for the transmit clock align and configuration port block.
// Assumes inclusion by bare name from files under src/.
`ifndef TCA_CONSTS_VH
`define TCA_CONSTS_VH

`define TCA_AXI_AW 8
`define TCA_REG_STATUS 8'h00
`define TCA_REG_MASK 8'h04
`define TCA_REG_STATE 8'h08
`define TCA_REG_LATCH 8'h0C

`define TCA_RESP_OKAY 2'h0
`define TCA_RESP_SLVERR 2'h2

`define TCA_CFG_ADDR_CLK 3'h0
`define TCA_LATCH_RST 4'h5
`define TCA_LB_SRC_SEL 0
`define TCA_LB_RATE_DBL 1
`define TCA_LB_RECENTER 2
`define TCA_LB_HALF_RATE 3

`define TCA_EV_ERR_SET 0
`define TCA_EV_ALIGNED 1
`define TCA_EV_CFG_WR 2
`define TCA_EV_W 3

`define TCA_RANGE_LOW 2'h0
`define TCA_RANGE_MID 2'h1
`define TCA_RANGE_HIGH 2'h2
`define TCA_RANGE_OH_LOW 3'h1
`define TCA_RANGE_OH_MID 3'h2
`define TCA_RANGE_OH_HIGH 3'h4

`define TCA_BUF_DEPTH 4
`define TCA_BUF_PW 3
`define TCA_BUF_CENTRE 3'h2
`define TCA_CHAR_W 10
`define TCA_HP_W 8
`define TCA_HP_MAX 8'hFF

`endif

// *** src/tca_top.v ***
// Transmit clock selection, phase alignment, clock out and config port.
// Assumes clk_i runs far faster than the reference and input clocks;
// pins other than the AXI bus are sampled through two-stage synchronisers.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "tca_consts.vh"
module tca_top (
  input wire clk_i,
  input wire resetn_i,
  input wire tx_input_clock_i,
  input wire reference_clock_i,
  input wire [`TCA_CHAR_W-1:0] tx_char_input_i,
  input wire cfg_write_strobe_n_i,
  input wire [2:0] cfg_addr_i,
  input wire [3:0] cfg_data_i,
  input wire [1:0] serial_speed_range_i,
  output reg tx_clock_out_o,
  output reg tx_path_error_o,
  output reg [`TCA_CHAR_W-1:0] char_out_o,
  output reg char_valid_o,
  output reg [2:0] pll_range_o,
  output reg irq_o,
  input wire [`TCA_AXI_AW-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`TCA_AXI_AW-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i
);
  // Synchroniser stages
  reg txclk_s1_q;
  reg txclk_s2_q;
  reg txclk_s3_q;
  reg ref_s1_q;
  reg ref_s2_q;
  reg ref_s3_q;
  reg [`TCA_CHAR_W-1:0] txd_s1_q;
  reg [`TCA_CHAR_W-1:0] txd_s2_q;
  reg [`TCA_CHAR_W-1:0] txd_s3_q;
  reg wrn_s1_q;
  reg wrn_s2_q;
  reg wrn_s3_q;
  reg [2:0] addr_s1_q;
  reg [2:0] addr_s2_q;
  reg [2:0] addr_s3_q;
  reg [3:0] data_s1_q;
  reg [3:0] data_s2_q;
  reg [3:0] data_s3_q;
  reg [1:0] spd_s1_q;
  reg [1:0] spd_s2_q;

  reg [3:0] latch_q;
  reg [3:0] latch_d;
  reg init_q;
  reg init_d;
  reg [`TCA_HP_W-1:0] hp_cnt_q;
  reg [`TCA_HP_W-1:0] hp_len_q;
  reg err_prev_q;
  reg rd_tick_q;
  reg [`TCA_EV_W-1:0] status_q;
  reg [`TCA_EV_W-1:0] status_d;
  reg [`TCA_EV_W-1:0] mask_q;

  reg [`TCA_AXI_AW-1:0] awaddr_q;
  reg aw_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_full_q;
  reg [31:0] rdata_d;
  reg rmapped_d;

  wire src_sel_w;
  wire rate_dbl_w;
  wire half_rate_w;
  wire ref_rise_w;
  wire ref_fall_w;
  wire ref_edge_w;
  wire txclk_rise_w;
  wire char_tick_w;
  wire wr_tick_w;
  wire status_tick_w;
  wire cfg_wr_w;
  wire cfg_hit_w;
  wire axi_wr_w;
  wire axi_hit_latch_w;
  wire axi_hit_status_w;
  wire axi_hit_mask_w;
  wire axi_wmapped_w;
  wire [`TCA_CHAR_W-1:0] buf_data_w;
  wire buf_err_w;
  wire [`TCA_BUF_PW-1:0] buf_level_w;
  wire [`TCA_HP_W-1:0] hp_mid_w;
  wire [`TCA_EV_W-1:0] ev_set_w;
  wire [`TCA_EV_W-1:0] ev_clr_w;

  // Every pin input except the AXI bus passes two flops before any logic
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txclk_s1_q <= 1'b0;
      txclk_s2_q <= 1'b0;
      txclk_s3_q <= 1'b0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      txd_s1_q <= {`TCA_CHAR_W{1'b0}};
      txd_s2_q <= {`TCA_CHAR_W{1'b0}};
      txd_s3_q <= {`TCA_CHAR_W{1'b0}};
      wrn_s1_q <= 1'b1;
      wrn_s2_q <= 1'b1;
      wrn_s3_q <= 1'b1;
      addr_s1_q <= 3'h0;
      addr_s2_q <= 3'h0;
      addr_s3_q <= 3'h0;
      data_s1_q <= 4'h0;
      data_s2_q <= 4'h0;
      data_s3_q <= 4'h0;
      spd_s1_q <= `TCA_RANGE_LOW;
      spd_s2_q <= `TCA_RANGE_LOW;
    end else begin
      txclk_s1_q <= tx_input_clock_i;
      txclk_s2_q <= txclk_s1_q;
      txclk_s3_q <= txclk_s2_q;
      ref_s1_q <= reference_clock_i;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      txd_s1_q <= tx_char_input_i;
      txd_s2_q <= txd_s1_q;
      txd_s3_q <= txd_s2_q;
      wrn_s1_q <= cfg_write_strobe_n_i;
      wrn_s2_q <= wrn_s1_q;
      wrn_s3_q <= wrn_s2_q;
      addr_s1_q <= cfg_addr_i;
      addr_s2_q <= addr_s1_q;
      addr_s3_q <= addr_s2_q;
      data_s1_q <= cfg_data_i;
      data_s2_q <= data_s1_q;
      data_s3_q <= data_s2_q;
      spd_s1_q <= serial_speed_range_i;
      spd_s2_q <= spd_s1_q;
    end
  end

  assign src_sel_w = latch_q[`TCA_LB_SRC_SEL];
  assign rate_dbl_w = latch_q[`TCA_LB_RATE_DBL];
  assign half_rate_w = latch_q[`TCA_LB_HALF_RATE];
  assign ref_rise_w = ref_s2_q & ~ref_s3_q;
  assign ref_fall_w = ~ref_s2_q & ref_s3_q;
  assign ref_edge_w = ref_rise_w | ref_fall_w;
  assign txclk_rise_w = txclk_s2_q & ~txclk_s3_q;
  // Character clock: every reference edge when doubled or half-rate
  assign char_tick_w = ref_rise_w | (ref_fall_w & (rate_dbl_w | half_rate_w));
  // Capture side: reference tick when source select is set, else input clock
  assign wr_tick_w = src_sel_w ? char_tick_w : txclk_rise_w;
  assign status_tick_w = ref_rise_w | (ref_fall_w & half_rate_w);

  // Config strobe: write on its return high, bus held around it
  assign cfg_wr_w = wrn_s2_q & ~wrn_s3_q;
  assign cfg_hit_w = cfg_wr_w & (addr_s3_q == `TCA_CFG_ADDR_CLK);

  assign axi_wr_w = aw_full_q & w_full_q & ~s_axi_bvalid_o;
  assign axi_hit_status_w = (awaddr_q[`TCA_AXI_AW-1:2] == `TCA_REG_STATUS >> 2);
  assign axi_hit_mask_w = (awaddr_q[`TCA_AXI_AW-1:2] == `TCA_REG_MASK >> 2);
  assign axi_hit_latch_w = (awaddr_q[`TCA_AXI_AW-1:2] == `TCA_REG_LATCH >> 2);
  assign axi_wmapped_w = axi_hit_status_w | axi_hit_mask_w | axi_hit_latch_w |
                         (awaddr_q[`TCA_AXI_AW-1:2] == `TCA_REG_STATE >> 2);

  // Latch update; pin port wins over the bus
  always @* begin
    latch_d = latch_q;
    init_d = 1'b0;
    if (cfg_hit_w) begin
      latch_d = data_s3_q;
    end else if (axi_wr_w && axi_hit_latch_w && wstrb_q[0]) begin
      latch_d = wdata_q[3:0];
    end
    if ((cfg_hit_w || (axi_wr_w && axi_hit_latch_w && wstrb_q[0])) &&
        !latch_d[`TCA_LB_RECENTER]) begin
      init_d = 1'b1;
    end
  end

  // Reset acts on this block only; no boundary-scan logic here
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_q <= `TCA_LATCH_RST;
      init_q <= 1'b1;
    end else begin
      latch_q <= latch_d;
      init_q <= init_d;
    end
  end

  tca_align_buf u_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .init_i(init_q),
    .wr_i(wr_tick_w),
    .wdata_i(txd_s3_q),
    .rd_i(char_tick_w),
    .rdata_o(buf_data_w),
    .err_o(buf_err_w),
    .level_o(buf_level_w)
  );

  // Half-period measure of the reference for the doubled clock
  assign hp_mid_w = {1'b0, hp_len_q[`TCA_HP_W-1:1]};

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hp_cnt_q <= {`TCA_HP_W{1'b0}};
      hp_len_q <= {`TCA_HP_W{1'b0}};
      tx_clock_out_o <= 1'b0;
    end else begin
      if (ref_edge_w) begin
        hp_cnt_q <= {`TCA_HP_W{1'b0}};
        hp_len_q <= hp_cnt_q;
      end else if (hp_cnt_q != `TCA_HP_MAX) begin
        hp_cnt_q <= hp_cnt_q + 8'h01;
      end
      if (!rate_dbl_w) begin
        tx_clock_out_o <= ref_s3_q;
      end else if (ref_edge_w) begin
        tx_clock_out_o <= 1'b1;
      end else if (hp_cnt_q == hp_mid_w) begin
        tx_clock_out_o <= 1'b0;
      end
    end
  end

  // Character output and error status
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_path_error_o <= 1'b0;
      char_out_o <= {`TCA_CHAR_W{1'b0}};
      char_valid_o <= 1'b0;
      err_prev_q <= 1'b0;
      rd_tick_q <= 1'b0;
    end else begin
      if (status_tick_w) begin
        tx_path_error_o <= buf_err_w;
      end
      err_prev_q <= tx_path_error_o;
      // Valid lags the read tick two cycles, in step with char_out_o
      rd_tick_q <= char_tick_w;
      char_valid_o <= rd_tick_q & ~tx_path_error_o & ~buf_err_w;
      char_out_o <= buf_data_w;
    end
  end

  // Three-level speed range to one-hot PLL range
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pll_range_o <= `TCA_RANGE_OH_LOW;
    end else begin
      case (spd_s2_q)
        `TCA_RANGE_LOW: pll_range_o <= `TCA_RANGE_OH_LOW;
        `TCA_RANGE_MID: pll_range_o <= `TCA_RANGE_OH_MID;
        `TCA_RANGE_HIGH: pll_range_o <= `TCA_RANGE_OH_HIGH;
        default: pll_range_o <= `TCA_RANGE_OH_MID;
      endcase
    end
  end

  // Interrupt events; set beats a same-cycle clear
  assign ev_set_w = {cfg_wr_w, err_prev_q & ~tx_path_error_o, ~err_prev_q & tx_path_error_o};
  assign ev_clr_w = (axi_wr_w && axi_hit_status_w && wstrb_q[0]) ?
                    wdata_q[`TCA_EV_W-1:0] : {`TCA_EV_W{1'b0}};

  always @* begin
    status_d = (status_q & ~ev_clr_w) | ev_set_w;
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_q <= {`TCA_EV_W{1'b0}};
      mask_q <= {`TCA_EV_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      status_q <= status_d;
      if (axi_wr_w && axi_hit_mask_w && wstrb_q[0]) begin
        mask_q <= wdata_q[`TCA_EV_W-1:0];
      end
      irq_o <= |(status_q & mask_q);
    end
  end

  // AXI4-Lite write channel: address and data in either order
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `TCA_RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= {`TCA_AXI_AW{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_q <= s_axi_awaddr_i;
        aw_full_q <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        w_full_q <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (axi_wr_w) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= axi_wmapped_w ? `TCA_RESP_OKAY : `TCA_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Read mux
  always @* begin
    rdata_d = 32'h00000000;
    rmapped_d = 1'b1;
    case (s_axi_araddr_i[`TCA_AXI_AW-1:2])
      `TCA_REG_STATUS >> 2: rdata_d[`TCA_EV_W-1:0] = status_q;
      `TCA_REG_MASK >> 2: rdata_d[`TCA_EV_W-1:0] = mask_q;
      `TCA_REG_STATE >> 2: rdata_d[10:0] = {buf_level_w, pll_range_o,
                                            tx_path_error_o, latch_q};
      `TCA_REG_LATCH >> 2: rdata_d[3:0] = latch_q;
      default: rmapped_d = 1'b0;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `TCA_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rdata_d;
        s_axi_rresp_o <= rmapped_d ? `TCA_RESP_OKAY : `TCA_RESP_SLVERR;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule // tca_top

// *** tb/tca_host_model.sv ***
// Host model: reference and input clocks, characters, config pins.
// Assumes clk_i at least eight times faster than the modelled clocks.
`timescale 1ns/100ps
module tca_host_model (
  input wire clk_i,
  input wire drift_i,
  output logic reference_clock_o,
  output logic tx_input_clock_o,
  output logic [9:0] tx_char_o,
  output logic strobe_n_o,
  output logic [2:0] addr_o,
  output logic [3:0] data_o
);
  logic [2:0] ref_cnt_q = 3'h0;
  logic [2:0] in_cnt_q = 3'h3;
  logic in_wrap;
  // Drift shortens the input half period by one cycle
  assign in_wrap = in_cnt_q >= (drift_i ? 3'h6 : 3'h7);
  initial begin
    reference_clock_o = 1'b0;
    tx_input_clock_o = 1'b0;
    tx_char_o = 10'h000;
    strobe_n_o = 1'b1;
    addr_o = 3'h7;
    data_o = 4'hF;
  end
  always @(posedge clk_i) begin
    ref_cnt_q <= ref_cnt_q + 3'h1;
    in_cnt_q <= in_wrap ? 3'h0 : in_cnt_q + 3'h1;
    if (ref_cnt_q == 3'h7) begin
      reference_clock_o <= ~reference_clock_o;
    end
    if (in_wrap) begin
      tx_input_clock_o <= ~tx_input_clock_o;
      if (!tx_input_clock_o) begin
        tx_char_o <= tx_char_o + 10'h001;
      end
    end
  end
  task automatic cfg_wr(input [2:0] a, input [3:0] d);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    repeat (5) @(posedge clk_i);
    strobe_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    strobe_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    // Released bus floats to the pull-up level
    addr_o <= 3'h7;
    data_o <= 4'hF;
  endtask
endmodule // tca_host_model

// *** tb/tca_top_monitor.sv ***
// Port checker for tca_top, bound to every instance.
// Assumes the tca_top port names; sees only those ports.
`timescale 1ns/100ps
module tca_top_monitor (
  input wire clk_i,
  input wire resetn_i,
  input wire [1:0] serial_speed_range_i,
  input wire [2:0] pll_range_o,
  input wire tx_path_error_o,
  input wire char_valid_o,
  input wire tx_clock_out_o,
  input wire cfg_write_strobe_n_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i
);
  logic [2:0] range_exp;
  logic [6:0] since_wr_q;
  logic [6:0] since_wr_d;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  assign range_exp = (serial_speed_range_i == 2'h0) ? 3'h1 :
                     (serial_speed_range_i == 2'h2) ? 3'h4 : 3'h2;
  // Cycles since the last config write of either port
  assign since_wr_d = (s_axi_bvalid_o || !cfg_write_strobe_n_i) ? 7'h00 :
                      (since_wr_q == 7'h7F) ? 7'h7F : since_wr_q + 7'h01;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_wr_q <= 7'h7F;
    end else begin
      since_wr_q <= since_wr_d;
    end
  end
  sequence s_clk_high;
    tx_clock_out_o [*2];
  endsequence
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  AST_RANGE_MAP: assert property ($stable(serial_speed_range_i) [*6] |-> pll_range_o == range_exp)
    else $error("range output does not follow pin");
  AST_RANGE_ONEHOT: assert property ($onehot(pll_range_o))
    else $error("range output not one-hot");
  AST_ERR_CLEAR: assert property ($fell(tx_path_error_o) |-> since_wr_q < 7'h40)
    else $error("error fell without a recentre write");
  AST_VALID_PULSE: assert property (char_valid_o |=> !char_valid_o)
    else $error("character valid longer than one cycle");
  AST_CLKOUT_HIGH: assert property ($rose(tx_clock_out_o) |-> s_clk_high)
    else $error("clock out high phase too short");
  AST_WR_RESP: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response missing");
  AST_B_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  AST_RD_RESP: assert property (s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read response missing");
  AST_RD_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
    else $error("read not released");
endmodule // tca_top_monitor

bind tca_top tca_top_monitor MON (.*);

// *** tb/testbench.sv ***
// Self-checking bench for tca_top over AXI4-Lite and the pin port.
// Assumes tca_host_model drives the pins and the checker is bound.
`timescale 1ns/100ps
module testbench;
  localparam logic [33:0] ALL = 34'h3_FFFF_FFFF;
  logic clk_i = 1'b0, resetn_i = 1'b0, drift = 1'b0, meas = 1'b0;
  logic tx_input_clock_i, reference_clock_i, cfg_write_strobe_n_i;
  logic tx_clock_out_o, tx_path_error_o, char_valid_o, irq_o;
  logic [9:0] tx_char_input_i, char_out_o;
  logic [2:0] cfg_addr_i, pll_range_o;
  logic [3:0] cfg_data_i, s_axi_wstrb_i = 4'hF;
  logic [1:0] serial_speed_range_i = 2'h0, s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rv;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [33:0] q[$], qm[$], mval, got, ex, mk;
  int miscompares = 0, tests_run = 0, seed = 32'h9654, cnt = 0, c0, i, vcnt = 0, v0;
  always #50 clk_i = ~clk_i;
  tca_top DUT (.*);
  tca_host_model HOST (.clk_i, .drift_i(drift), .reference_clock_o(reference_clock_i),
    .tx_input_clock_o(tx_input_clock_i), .tx_char_o(tx_char_input_i),
    .strobe_n_o(cfg_write_strobe_n_i), .addr_o(cfg_addr_i), .data_o(cfg_data_i));
  always @(posedge tx_clock_out_o) cnt++;
  always @(posedge clk_i) if (char_valid_o) vcnt++;
  // Result watcher: oldest note against each response or sample
  always @(posedge clk_i) begin
    if ((s_axi_bvalid_o && s_axi_bready_i) || (s_axi_rvalid_o && s_axi_rready_i) || meas) begin
      got = meas ? mval : (s_axi_bvalid_o && s_axi_bready_i) ? {s_axi_bresp_o, 32'h0} :
            {s_axi_rresp_o, s_axi_rdata_o};
      ex = q.pop_front();
      mk = qm.pop_front();
      tests_run++;
      if ((got & mk) !== ex) begin
        miscompares++;
        $display("[ERR] %0t exp %h got %h", $time, ex, got & mk);
      end
    end
  end
  task automatic note(input [33:0] e, input [33:0] m);
    q.push_back(e);
    qm.push_back(m);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    note({r, 32'h0}, ALL);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [33:0] e, input [33:0] m);
    note(e, m);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic sample(input [33:0] e, input [33:0] v);
    note(e, ALL);
    @(posedge clk_i);
    mval <= v;
    meas <= 1'b1;
    @(posedge clk_i);
    meas <= 1'b0;
  endtask
  // Clock-out rises or valid pulses over eight reference periods
  task automatic clk_count(input [33:0] e, input bit v);
    @(posedge reference_clock_i);
    c0 = cnt;
    v0 = vcnt;
    repeat (8) @(posedge reference_clock_i);
    sample(e, v ? 34'(vcnt - v0) : 34'(cnt - c0));
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      serial_speed_range_i <= i[1:0];
      repeat (8) @(posedge clk_i);
      rd(8'h08, 34'h205 | ((i == 3) ? 34'h40 : (34'h20 << i)), ALL);
    end
    rd(8'h0C, 34'h5, ALL);
    rd(8'h04, 34'h0, ALL);
    rd(8'h10, 34'h2_0000_0000, ALL);
    wr(8'h14, 32'h1, 2'h2);
    $display("test reset done");
    clk_count(34'd8, 1'b0);
    wr(8'h0C, 32'h7, 2'h0);
    repeat (40) @(posedge clk_i);
    clk_count(34'd16, 1'b0);
    wr(8'h0C, 32'h5, 2'h0);
    $display("test rate done");
    HOST.cfg_wr(3'h0, 4'h0);
    HOST.cfg_wr(3'h3, 4'hF);
    rd(8'h0C, 34'h0, ALL);
    rd(8'h00, 34'h4, 34'h7);
    wr(8'h00, 32'h7, 2'h0);
    repeat (300) @(posedge clk_i);
    rd(8'h08, 34'h0, 34'h10);
    rv = $random(seed) | 32'h1;
    wr(8'h04, rv, 2'h0);
    rd(8'h04, {31'h0, rv[2:0]}, ALL);
    // Byte 0 strobe low: write answered but mask kept
    s_axi_wstrb_i <= 4'hE;
    wr(8'h04, 32'h0, 2'h0);
    s_axi_wstrb_i <= 4'hF;
    rd(8'h04, {31'h0, rv[2:0]}, ALL);
    $display("test pin port done");
    drift <= 1'b1;
    repeat (800) @(posedge clk_i);
    drift <= 1'b0;
    repeat (40) @(posedge clk_i);
    rd(8'h08, 34'h10, 34'h10);
    rd(8'h00, 34'h1, 34'h3);
    sample(34'h1, {33'h0, irq_o});
    wr(8'h04, 32'h0, 2'h0);
    repeat (2) @(posedge clk_i);
    sample(34'h0, {33'h0, irq_o});
    wr(8'h04, 32'h1, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    repeat (2) @(posedge clk_i);
    sample(34'h0, {33'h0, irq_o});
    repeat (200) @(posedge clk_i);
    rd(8'h08, 34'h10, 34'h10);
    $display("test drift done");
    wr(8'h0C, 32'h0, 2'h0);
    repeat (100) @(posedge clk_i);
    rd(8'h08, 34'h0, 34'h10);
    rd(8'h00, 34'h2, 34'h2);
    // Consecutive captured characters step by one
    do @(posedge clk_i); while (!char_valid_o);
    rv = {22'h0, char_out_o};
    do @(posedge clk_i); while (!char_valid_o);
    sample({24'h0, rv[9:0] + 10'h001}, {24'h0, char_out_o});
    $display("test recenter done");
    wr(8'h0C, 32'hD, 2'h0);
    repeat (40) @(posedge clk_i);
    clk_count(34'd16, 1'b1);
    $display("test half rate done");
    wrap_up;
  end
endmodule // testbench
